// ### rtl/offl_pkg.sv
// Constants shared by the output flip-flop force and lock register bank.
// Assumes an APB slave on a 32-bit bus with word-aligned registers.
package offl_pkg;

    // =====================================================================
    // Register indices (byte address is four times the index)
    // =====================================================================
    localparam logic [29:0] IDX_FORCED_0_15  = 30'h0080_0226;
    localparam logic [29:0] IDX_FORCED_16_20 = 30'h0080_022b;
    localparam logic [29:0] IDX_FORCED_21_28 = 30'h0080_07d7;
    localparam logic [29:0] IDX_LOCK_29_36   = 30'h0080_0bd5;
    localparam logic [29:0] IDX_FORCED_29_36 = 30'h0080_0bd7;
    localparam logic [29:0] IDX_LOCK_37_44   = 30'h0080_0cd5;

    // =====================================================================
    // Flip-flop numbering and field layout
    // =====================================================================
    localparam int NUM_FF       = 37;
    localparam int LOCK_LO      = 29;
    localparam int LOCK_HI      = 44;
    localparam int FF_BASE_D1   = 16;
    localparam int FD1_WIDTH    = 5;
    localparam int FF_TOP_D2    = 28;
    localparam int FF_TOP_D3    = 36;
    localparam int FF_TOP_L4    = 44;
    localparam int BYTE_WIDTH   = 8;
    localparam int HALF_WIDTH   = 16;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [15:0] LOCK_RESET   = 16'h0000;
    localparam logic [36:0] FORCE_RESET  = 37'h00_0000_0000;
    localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

endpackage

// ### rtl/offl_if.sv
// Carrier between the register front end and the output flip-flop bank.
// Both ends run on the same peripheral clock.
`timescale 1ns/10ps
interface offl_if #(
    parameter int N = 37
);
    logic [N-1:0] force_we;
    logic [N-1:0] force_val;
    logic [N-1:0] step;
    logic [N-1:0] q;

    modport ctl  (output force_we, output force_val, output step, input q);
    modport bank (input force_we, input force_val, input step, output q);
endinterface

// ### rtl/offl_ffbank.sv
// Bank of timer output flip-flops with a software force path.
// Assumes force and step requests are already qualified by the front end.
`timescale 1ns/10ps
module offl_ffbank #(
    parameter int N = 37
) (
    input wire logic pclk,
    input wire logic presetn,
    offl_if.bank     ffs
);

    // =====================================================================
    // Flip-flops
    // =====================================================================
    // A forced value beats a timer event arriving in the same cycle, so a
    // software level is never lost to a coincident toggle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ffs.q <= offl_pkg::FORCE_RESET[N-1:0];
        end else begin
            for (int i = 0; i < N; i++) begin
                if (ffs.force_we[i]) begin
                    ffs.q[i] <= ffs.force_val[i];
                end else if (ffs.step[i]) begin
                    ffs.q[i] <= ~ffs.q[i];
                end
            end
        end
    end

endmodule

// ### rtl/offl_top.sv
// APB register bank that forces and write-locks timer output flip-flops.
// Assumes event inputs and external locks come from logic on pclk.
//
// Summary of operation
// - A lock bit of 0 lets software write its flip-flop's forced-data bit, 1 forbids it.
// - A forced-data write to a locked flip-flop is ignored and the output keeps its level.
// - Each lock bit acts alone, so unlocked neighbours in the same register still take writes.
// - Writing 0 or 1 to a forced-data bit loads that value straight into the flip-flop.
// - Without forcing, each flip-flop changes state on events of its selected timer source.
// - Every unlocked flip-flop can be forced to any level whatever its timer is doing.
// - In the 16-bit register D0 belongs to flip-flop 0, ascending to D15 for flip-flop 15.
// - In the 16-20 register D0 is flip-flop 16 up to D4 for 20, and D5 and above are unused.
// - In the 21-28 register D0 is flip-flop 28, descending to D7 for flip-flop 21.
// - In the 29-36 register D0 is flip-flop 36, descending to D7 for flip-flop 29.
// - Each flip-flop's source is a timer output or an event bus line chosen by a select.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module offl_top #(
    parameter int N = offl_pkg::NUM_FF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [28:0] ext_lock_0_28,
    input  wire logic [N-1:0] src_sel,
    input  wire logic [N-1:0] timer_evt,
    input  wire logic [N-1:0] bus_evt,
    output logic [N-1:0]     ff_out
);

    // =====================================================================
    // Declarations
    // =====================================================================
    localparam int LH = offl_pkg::LOCK_HI;
    localparam int LL = offl_pkg::LOCK_LO;

    offl_if #(.N(N)) ffs ();

    logic [LH:LL]  lock_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic          setup;
    logic          wr_fire;
    logic [5:0]    hit;
    logic          mapped;
    logic [N-1:0]  lock_all;
    logic [31:0]   rd_nxt;
    logic [N-1:0]  force_we_nxt;
    logic [N-1:0]  force_val_nxt;

    localparam int H_D0 = 0;
    localparam int H_D1 = 1;
    localparam int H_D2 = 2;
    localparam int H_L3 = 3;
    localparam int H_D3 = 4;
    localparam int H_L4 = 5;

    // =====================================================================
    // Address decode
    // =====================================================================
    assign setup   = psel & ~penable;
    assign wr_fire = psel & penable & pwrite & pready_r;

    always_comb begin
        hit = 6'h00;
        if (paddr[1:0] == 2'b00) begin
            hit[H_D0] = (paddr[31:2] == offl_pkg::IDX_FORCED_0_15);
            hit[H_D1] = (paddr[31:2] == offl_pkg::IDX_FORCED_16_20);
            hit[H_D2] = (paddr[31:2] == offl_pkg::IDX_FORCED_21_28);
            hit[H_L3] = (paddr[31:2] == offl_pkg::IDX_LOCK_29_36);
            hit[H_D3] = (paddr[31:2] == offl_pkg::IDX_FORCED_29_36);
            hit[H_L4] = (paddr[31:2] == offl_pkg::IDX_LOCK_37_44);
        end
    end

    assign mapped   = |hit;
    assign lock_all = {lock_r[offl_pkg::FF_TOP_D3:LL], ext_lock_0_28};

    // =====================================================================
    // Read images
    // =====================================================================
    always_comb begin
        rd_nxt = offl_pkg::RDATA_RESET;
        if (hit[H_D0]) begin
            rd_nxt[offl_pkg::HALF_WIDTH-1:0] = ffs.q[15:0];
        end
        if (hit[H_D1]) begin
            rd_nxt[offl_pkg::FD1_WIDTH-1:0] = ffs.q[20:16];
        end
        for (int k = 0; k < offl_pkg::BYTE_WIDTH; k++) begin
            if (hit[H_D2]) begin
                rd_nxt[k] = ffs.q[offl_pkg::FF_TOP_D2-k];
            end
            if (hit[H_D3]) begin
                rd_nxt[k] = ffs.q[offl_pkg::FF_TOP_D3-k];
            end
            if (hit[H_L3]) begin
                rd_nxt[k] = lock_r[offl_pkg::FF_TOP_D3-k];
            end
            if (hit[H_L4]) begin
                rd_nxt[k] = lock_r[offl_pkg::FF_TOP_L4-k];
            end
        end
    end

    // =====================================================================
    // Force requests
    // =====================================================================
    // The lock is checked bit by bit, so a write to a partly locked
    // register still reaches its unlocked flip-flops.
    always_comb begin
        force_we_nxt  = '0;
        force_val_nxt = '0;
        if (wr_fire && hit[H_D0] && (pstrb[1:0] == 2'b11)) begin
            for (int i = 0; i < offl_pkg::HALF_WIDTH; i++) begin
                force_we_nxt[i]  = ~lock_all[i];
                force_val_nxt[i] = pwdata[i];
            end
        end
        if (wr_fire && hit[H_D1] && pstrb[0]) begin
            for (int i = 0; i < offl_pkg::FD1_WIDTH; i++) begin
                force_we_nxt[offl_pkg::FF_BASE_D1+i]  = ~lock_all[offl_pkg::FF_BASE_D1+i];
                force_val_nxt[offl_pkg::FF_BASE_D1+i] = pwdata[i];
            end
        end
        for (int k = 0; k < offl_pkg::BYTE_WIDTH; k++) begin
            if (wr_fire && hit[H_D2] && pstrb[0]) begin
                force_we_nxt[offl_pkg::FF_TOP_D2-k]  = ~lock_all[offl_pkg::FF_TOP_D2-k];
                force_val_nxt[offl_pkg::FF_TOP_D2-k] = pwdata[k];
            end
            if (wr_fire && hit[H_D3] && pstrb[0]) begin
                force_we_nxt[offl_pkg::FF_TOP_D3-k]  = ~lock_all[offl_pkg::FF_TOP_D3-k];
                force_val_nxt[offl_pkg::FF_TOP_D3-k] = pwdata[k];
            end
        end
    end

    assign ffs.force_we  = force_we_nxt;
    assign ffs.force_val = force_val_nxt;
    assign ffs.step      = src_sel & bus_evt | ~src_sel & timer_evt;

    offl_ffbank #(.N(N)) u_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .ffs     (ffs)
    );

    assign ff_out = ffs.q;

    // =====================================================================
    // Lock registers
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= offl_pkg::LOCK_RESET;
        end else if (wr_fire && pstrb[0]) begin
            for (int k = 0; k < offl_pkg::BYTE_WIDTH; k++) begin
                if (hit[H_L3]) begin
                    lock_r[offl_pkg::FF_TOP_D3-k] <= pwdata[k];
                end
                if (hit[H_L4]) begin
                    lock_r[offl_pkg::FF_TOP_L4-k] <= pwdata[k];
                end
            end
        end
    end

    // =====================================================================
    // APB answer
    // =====================================================================
    // Read data are captured in the setup cycle so that prdata leaves a
    // flip-flop; the cost is that a force landing in that same cycle is
    // not yet visible in the value read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= offl_pkg::RDATA_RESET;
        end else if (setup) begin
            prdata_r <= pwrite ? offl_pkg::RDATA_RESET : rd_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= ~mapped | (pwrite & hit[H_D0] & (pstrb[1:0] != 2'b11));
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup(logic [5:0] h);
        psel && !penable && (h != 6'h00);
    endsequence

    sequence s_access;
        psel && penable && pready_r;
    endsequence

    locked_blocked_a : assert property ((force_we_nxt & lock_all) == '0)
        else $error("force issued to a locked flip-flop");

    locked_hold_a : assert property (
        wr_fire && hit[H_D3] && lock_r[LL] && !ffs.step[LL] |=> $stable(ff_out[LL]))
        else $error("locked flip-flop changed on a write");

    neighbour_free_a : assert property (
        wr_fire && hit[H_D3] && pstrb[0] && !lock_r[LL+1] |-> force_we_nxt[LL+1])
        else $error("unlocked neighbour refused a write");

    force_load_a : assert property (
        |force_we_nxt |=> ((ff_out ^ $past(force_val_nxt)) & $past(force_we_nxt)) == '0)
        else $error("forced value not loaded");

    toggle_step_a : assert property (
        |(ffs.step & ~force_we_nxt) |=>
            ((ff_out ^ ~$past(ff_out)) & $past(ffs.step & ~force_we_nxt)) == '0)
        else $error("flip-flop missed a source event");

    quiet_hold_a : assert property (
        (ffs.step | force_we_nxt) == '0 |=> $stable(ff_out))
        else $error("flip-flop moved without cause");

    half_only_a : assert property (
        s_setup(hit) ##0 (pwrite && hit[H_D0] && pstrb[1:0] != 2'b11) |=> pslverr && pready
            ##0 (force_we_nxt[15:0] == '0))
        else $error("byte write to halfword register accepted");

    map_d0_a : assert property (
        s_setup(hit) ##0 (!pwrite && hit[H_D0]) |=>
            s_access ##0 prdata[15:0] == $past(ff_out[15:0]))
        else $error("halfword register read mapping wrong");

    map_d0_write_a : assert property (
        wr_fire && hit[H_D0] && pstrb[1:0] == 2'b11 && !lock_all[0]
            |=> ff_out[0] == $past(pwdata[0]))
        else $error("halfword register write mapping wrong");

    unused_zero_a : assert property (
        s_setup(hit) ##0 (!pwrite && hit[H_D1]) |=> prdata[31:5] == 27'h000_0000
            && prdata[0] == $past(ff_out[16]))
        else $error("unused bits not zero");

    map_d1_write_a : assert property (
        wr_fire && hit[H_D1] && pstrb[0] && !lock_all[20]
            |=> ff_out[20] == $past(pwdata[4]))
        else $error("register 1 write mapping wrong");

    map_d2_a : assert property (
        s_setup(hit) ##0 (!pwrite && hit[H_D2]) |=> prdata[7] == $past(ff_out[21])
            && prdata[0] == $past(ff_out[28]))
        else $error("register 2 mapping wrong");

    map_d3_a : assert property (
        wr_fire && hit[H_D3] && pstrb[0] && !lock_r[LL] |=> ff_out[LL] == $past(pwdata[7]))
        else $error("register 3 mapping wrong");

    lock_order_a : assert property (
        wr_fire && hit[H_L4] && pstrb[0] |=> lock_r[LH] == $past(pwdata[0])
            && lock_r[LH-7] == $past(pwdata[7]))
        else $error("lock bit order wrong");

    lock_write_a : assert property (
        wr_fire && hit[H_L3] && pstrb[0] |=> lock_r[LL] == $past(pwdata[7]))
        else $error("lock register 3 order wrong");

    strobe_gate_a : assert property (
        wr_fire && (hit[H_L3] || hit[H_L4]) && !pstrb[0] |=> $stable(lock_r))
        else $error("lock written without its byte strobe");

    src_pick_a : assert property (
        |(~force_we_nxt & src_sel & timer_evt & ~bus_evt) |=>
            ((ff_out ^ $past(ff_out)) & $past(~force_we_nxt & src_sel & timer_evt & ~bus_evt))
                == '0)
        else $error("unselected source moved a flip-flop");

    answer_once_a : assert property (setup |=> pready ##1 !pready || setup)
        else $error("ready not a single cycle");

endmodule

// ### tb/tb_output_flipflop_force_and_lock.sv
// Self-checking bench for the output flip-flop force and lock register bank.
// Assumes offl_top is an APB slave on pclk; the bus task waits for pready however long.
`timescale 1ns/10ps
module tb_output_flipflop_force_and_lock;
    // ==================================================================
    // Clock, reset and stimulus signals
    // ==================================================================
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [28:0] ext_lock_0_28;
    logic [36:0] src_sel;
    logic [36:0] timer_evt;
    logic [36:0] bus_evt;
    logic [36:0] ff_out;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          total_checks;

    offl_top u_dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .pstrb         (pstrb),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .ext_lock_0_28 (ext_lock_0_28),
        .src_sel       (src_sel),
        .timer_evt     (timer_evt),
        .bus_evt       (bus_evt),
        .ff_out        (ff_out)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic chk(input string name, input logic [36:0] got, input logic [36:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Design outputs are all registered, so values read at the edge are the settled ones.
    task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic pulse(input int i, input logic on_bus);
        @(posedge pclk);
        if (on_bus) bus_evt[i] <= 1'b1;
        else timer_evt[i] <= 1'b1;
        @(posedge pclk);
        bus_evt   <= 37'h0;
        timer_evt <= 37'h0;
        @(negedge pclk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_reset();
        logic [29:0] idx [6];
        idx = '{offl_pkg::IDX_FORCED_0_15, offl_pkg::IDX_FORCED_16_20,
                offl_pkg::IDX_FORCED_21_28, offl_pkg::IDX_LOCK_29_36,
                offl_pkg::IDX_FORCED_29_36, offl_pkg::IDX_LOCK_37_44};
        chk("ff_out reset", ff_out, 37'h00_0000_0000);
        foreach (idx[i]) begin
            apb(1'b0, idx[i], 32'h0000_0000, 4'h0);
            chk("reset read", 37'(rd), 37'h0);
        end
    endtask

    task automatic t_data0();
        apb(1'b1, offl_pkg::IDX_FORCED_0_15, 32'h0000_A5CB, 4'h3);
        chk("data0 ff", 37'(ff_out[15:0]), 37'h0_A5CB);
        apb(1'b0, offl_pkg::IDX_FORCED_0_15, 32'h0000_0000, 4'h0);
        chk("data0 read", 37'(rd[15:0]), 37'h0_A5CB);
        // A byte-wide write must be refused whole.
        apb(1'b1, offl_pkg::IDX_FORCED_0_15, 32'h0000_0000, 4'h1);
        chk("data0 byte err", 37'(err), 37'h1);
        chk("data0 byte ff", 37'(ff_out[15:0]), 37'h0_A5CB);
        @(posedge pclk);
        ext_lock_0_28 <= 29'h0000_0008;
        apb(1'b1, offl_pkg::IDX_FORCED_0_15, 32'h0000_0000, 4'h3);
        chk("data0 locked", 37'(ff_out[15:0]), 37'h0_0008);
        @(posedge pclk);
        ext_lock_0_28 <= 29'h0000_0000;
        apb(1'b1, offl_pkg::IDX_FORCED_0_15, 32'h0000_0000, 4'h3);
        chk("data0 unlocked", 37'(ff_out[15:0]), 37'h0_0000);
    endtask

    task automatic t_data1_2();
        apb(1'b1, offl_pkg::IDX_FORCED_16_20, 32'h0000_00FF, 4'h1);
        chk("data1 ff", 37'(ff_out[20:16]), 37'h1F);
        apb(1'b0, offl_pkg::IDX_FORCED_16_20, 32'h0000_0000, 4'h0);
        chk("data1 read", 37'(rd), 37'h1F);
        apb(1'b1, offl_pkg::IDX_FORCED_21_28, 32'h0000_0080, 4'h1);
        chk("data2 ff", 37'(ff_out[28:21]), 37'h01);
        apb(1'b1, offl_pkg::IDX_FORCED_21_28, 32'h0000_0001, 4'h1);
        chk("data2 ff top", 37'(ff_out[28:21]), 37'h80);
    endtask

    task automatic t_locks();
        apb(1'b1, offl_pkg::IDX_LOCK_29_36, 32'h0000_0081, 4'h1);
        apb(1'b0, offl_pkg::IDX_LOCK_29_36, 32'h0000_0000, 4'h0);
        chk("lock3 read", 37'(rd), 37'h81);
        apb(1'b1, offl_pkg::IDX_FORCED_29_36, 32'h0000_00FF, 4'h1);
        chk("data3 ff", 37'(ff_out[36:29]), 37'h7E);
        apb(1'b0, offl_pkg::IDX_FORCED_29_36, 32'h0000_0000, 4'h0);
        chk("data3 read", 37'(rd), 37'h7E);
        apb(1'b1, offl_pkg::IDX_LOCK_37_44, 32'h0000_005A, 4'h1);
        apb(1'b1, offl_pkg::IDX_LOCK_37_44, 32'h0000_00FF, 4'h2);
        apb(1'b0, offl_pkg::IDX_LOCK_37_44, 32'h0000_0000, 4'h0);
        chk("lock4 read", 37'(rd), 37'h5A);
        apb(1'b0, 30'h0000_0100, 32'h0000_0000, 4'h0);
        chk("unmapped err", 37'(err), 37'h1);
        chk("unmapped read", 37'(rd), 37'h0);
        // Clearing the lock lets the lowest flip-flop of the register take its bit again.
        apb(1'b1, offl_pkg::IDX_LOCK_29_36, 32'h0000_0000, 4'h1);
        apb(1'b1, offl_pkg::IDX_FORCED_29_36, 32'h0000_0080, 4'h1);
        chk("data3 unlocked", 37'(ff_out[36:29]), 37'h01);
    endtask

    task automatic t_reset_mid();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("ff_out rerun", ff_out, 37'h00_0000_0000);
        apb(1'b0, offl_pkg::IDX_LOCK_37_44, 32'h0000_0000, 4'h0);
        chk("lock4 rerun", 37'(rd), 37'h0);
    endtask

    task automatic t_events();
        @(posedge pclk);
        src_sel <= 37'h00_0000_0040;
        pulse(5, 1'b0);
        chk("timer toggle", 37'(ff_out[5]), 37'h1);
        pulse(6, 1'b0);
        chk("timer unselected", 37'(ff_out[6]), 37'h0);
        pulse(6, 1'b1);
        chk("bus toggle", 37'(ff_out[6]), 37'h1);
        pulse(5, 1'b0);
        chk("timer toggle back", 37'(ff_out[5]), 37'h0);
        apb(1'b1, offl_pkg::IDX_FORCED_0_15, 32'h0000_0000, 4'h3);
        chk("force after events", 37'(ff_out[15:0]), 37'h0);
    endtask

    // ==================================================================
    // Main sequence and watchdog
    // ==================================================================
    initial begin
        n_fail = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        ext_lock_0_28 = 29'h0000_0000;
        src_sel = 37'h0;
        timer_evt = 37'h0;
        bus_evt = 37'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_data0();
        t_data1_2();
        t_locks();
        t_events();
        t_reset_mid();
        stop_test();
    end

    // The whole run takes about a hundred cycles, so this only trips on a hang.
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
endmodule
